// ==== src/vfddr_transfer_sequencer.sv ====
// Drain sequencer moving luma and chroma queues onto the bus
`timescale 1ns/100ps
`default_nettype none
// How it works
// RULE1 - After sync, fetch instructions and burst aligned data
// RULE2 - Wait for trigger level before WRITE
// RULE3 - Skip trigger when remainder below queue contents
// RULE4 - SKIP ignores the trigger level
// RULE5 - Software sets equal trigger levels in planar
// RULE6 - Planar disconnect: bypass trigger, re-request, flush
// RULE7 - Packed mode drains three queues as one
// RULE8 - Fetch parity error halts everything, flags it; in planar mode full chroma queues are still popped while in S_HALT
// RULE9 - Bus denied: pop and discard as if sent
// RULE10 - Track line bytes, resume after overrun clears
// RULE11 - Luma queue 70 deep, levels 68/64
// RULE12 - Chroma queues 35 deep, levels 34/32
// RULE13 - Start address only below nearly-full; never full
// RULE14 - Check all three queue counters always
// RULE15 - Overflow awaiting target: end, discard, flag slow
// RULE16 - Overrun spans next instruction, else whole line
// RULE17 - Count lines dropped while denied, realign later
// RULE18 - Planar favours luma; full chroma discarded concurrently
// RULE19 - Early queue line end aborts to program line end
// RULE20 - Long line: discard until queue line end
// RULE21 - Early field end aborts until matching SYNC
// RULE22 - Late field end: discard until SYNC matches
// RULE23 - Any length correction sets resync flag
// RULE24 - SYNC matches four head status bits
// RULE25 - Line start/end flags bound each scan line
// RULE26 - Two-bit trigger field: 4, 8, 16, 32
module vfddr_transfer_sequencer (
	input wire logic REF_CLK, // Bus clock
	input wire logic RSTN, // Synchronous reset, active low
	input wire logic [3:0] REG_ADDR, // Register byte address
	input wire logic [31:0] REG_WDATA, // Register write data
	input wire logic REG_WR, // Write strobe
	input wire logic REG_RD, // Read strobe
	output logic [31:0] REG_RDATA, // Read data, cycle after strobe
	input wire vfddr_pkg::vfddr_insn_t INSN, // Prefetched instruction
	input wire logic INSN_VALID, // Instruction available
	output logic INSN_TAKE, // Instruction consumed
	input wire logic FETCH_PERR, // Parity error on instruction read
	input wire logic [6:0] LUMA_CNT, // Luma queue occupancy
	input wire logic [5:0] CHA_CNT, // Chroma queue A occupancy
	input wire logic [5:0] CHB_CNT, // Chroma queue B occupancy
	input wire vfddr_pkg::vfddr_head_t HEAD, // Codes at queue head
	output logic LUMA_POP, // Pop luma queue
	output logic CHA_POP, // Pop chroma queue A
	output logic CHB_POP, // Pop chroma queue B
	output logic BUS_REQ, // Bus request
	input wire logic BUS_GNT, // Bus grant
	output logic BUS_START, // Address phase
	input wire logic BUS_TRDY, // Target ready
	input wire logic BUS_STOP, // Target disconnect
	output logic BUS_PUSH, // Popped DWORD goes on the bus
	output logic BUS_LAST // Last cycle of transaction
);
	vfddr_pkg::vfddr_state_t state_reg;
	vfddr_pkg::vfddr_state_t fetch_dest;
	vfddr_pkg::vfddr_insn_t cur_reg;
	logic [11:0] rem_reg;
	logic [11:0] step;
	logic [11:0] line_pos_reg;
	logic [7:0] owed_reg;
	logic [3:0] ctrl_reg;
	logic [2:0] sts_reg;
	logic [2:0] sts_set;
	logic [31:0] rd_next;
	logic [31:0] rd_reg;
	logic synced_reg, fend_abort_reg, flush_reg, ovr_reg;
	logic disc_reg, ovf_pend_reg, drop_owe_reg;
	logic enable, planar, any_full, any_nfull, cha_full, chb_full;
	logic [7:0] avail, trig_dw;
	logic [9:0] rem_dw;
	logic can_pop, deq, done, end_insn, fend_at_head, trig_ok;
	logic sync_hit, perr_ev, aborting, lend_early, line_long;
	logic moving;

	assign enable = ctrl_reg[vfddr_pkg::CTRL_ENABLE_BIT];
	assign planar = ctrl_reg[vfddr_pkg::CTRL_PLANAR_BIT];
	assign trig_dw = vfddr_pkg::TRIG_BASE_DW
		<< ctrl_reg[vfddr_pkg::CTRL_TRIG_LSB +: 2]; // RULE26

	// Levels are checked on every queue whatever the mode
	assign cha_full = CHA_CNT >= vfddr_pkg::CHROMA_FULL_LEVEL; // RULE12
	assign chb_full = CHB_CNT >= vfddr_pkg::CHROMA_FULL_LEVEL; // RULE12
	assign any_full = LUMA_CNT >= vfddr_pkg::LUMA_FULL_LEVEL
		|| cha_full || chb_full; // RULE14
	assign any_nfull = LUMA_CNT >= vfddr_pkg::LUMA_NEARLY_FULL_LEVEL
		|| CHA_CNT >= vfddr_pkg::CHROMA_NEARLY_FULL_LEVEL
		|| CHB_CNT >= vfddr_pkg::CHROMA_NEARLY_FULL_LEVEL; // RULE11

	// Packed mode sees one big queue; planar drains luma only
	assign avail = planar ? {1'b0, LUMA_CNT}
		: {1'b0, LUMA_CNT} + {2'b00, CHA_CNT} + {2'b00, CHB_CNT}; // RULE7
	assign can_pop = avail != 8'h00;
	assign rem_dw = 10'((13'(rem_reg) + 13'h0003) >> 2);
	assign trig_ok = disc_reg || avail >= trig_dw // RULE2 RULE6
		|| {2'b00, avail} > rem_dw; // RULE3
	assign step = rem_reg > vfddr_pkg::DWORD_BYTES
		? vfddr_pkg::DWORD_BYTES : rem_reg;
	assign done = rem_reg <= vfddr_pkg::DWORD_BYTES;
	assign sync_hit = HEAD.field_end && HEAD.status == cur_reg.status;
	assign perr_ev = enable && FETCH_PERR && state_reg != vfddr_pkg::S_HALT;
	assign moving = state_reg == vfddr_pkg::S_BURST
		|| state_reg == vfddr_pkg::S_DROP;
	// A field end is left at the head so the SYNC can match it
	assign fend_at_head = can_pop && HEAD.field_end && (moving
		|| state_reg == vfddr_pkg::S_LDROP); // RULE21
	assign aborting = !synced_reg || fend_abort_reg || flush_reg
		|| owed_reg != 8'h00;

	// Dequeue decision; SKIP and discard never wait for the trigger
	always_comb begin
		deq = 1'b0;
		BUS_PUSH = 1'b0;
		unique case (state_reg)
			vfddr_pkg::S_SYNC: deq = can_pop; // RULE24 RULE22
			vfddr_pkg::S_LDROP: deq = can_pop && !fend_at_head; // RULE20
			vfddr_pkg::S_DROP: begin
				deq = can_pop && !fend_at_head && rem_reg != 12'h000; // RULE4 RULE9
			end
			vfddr_pkg::S_BURST: begin
				BUS_PUSH = BUS_TRDY && can_pop && !fend_at_head
					&& rem_reg != 12'h000; // RULE1
				deq = BUS_PUSH;
			end
			vfddr_pkg::S_IDLE, vfddr_pkg::S_FETCH, vfddr_pkg::S_TRIG,
			vfddr_pkg::S_REQ, vfddr_pkg::S_ADDR, vfddr_pkg::S_RESP,
			vfddr_pkg::S_HALT: deq = 1'b0;
		endcase
	end

	assign end_insn = deq && moving && (HEAD.line_end_flag || done);
	assign lend_early = end_insn && HEAD.line_end_flag
		&& !cur_reg.line_end_flag; // RULE19
	assign line_long = end_insn && done && cur_reg.line_end_flag
		&& !HEAD.line_end_flag; // RULE20

	// Queue pops; full chroma is shed while luma bursts
	assign LUMA_POP = deq && (planar || LUMA_CNT != 7'h00);
	assign CHA_POP = planar ? cha_full // RULE18
		: deq && LUMA_CNT == 7'h00 && CHA_CNT != 6'h00; // RULE7
	assign CHB_POP = planar ? chb_full // RULE18
		: deq && LUMA_CNT == 7'h00 && CHA_CNT == 6'h00;

	// Bus handshake outputs
	assign BUS_REQ = state_reg == vfddr_pkg::S_REQ;
	assign BUS_START = state_reg == vfddr_pkg::S_ADDR; // RULE13
	assign BUS_LAST = (state_reg == vfddr_pkg::S_RESP && BUS_TRDY
		&& ovf_pend_reg) // RULE15
		|| (state_reg == vfddr_pkg::S_BURST && (end_insn
		|| fend_at_head || (!can_pop && !BUS_STOP)));
	assign INSN_TAKE = state_reg == vfddr_pkg::S_FETCH && INSN_VALID
		&& enable && !perr_ev;

	// Where a fetched instruction sends the sequencer
	always_comb begin
		if (INSN.op == vfddr_pkg::OP_SYNC) begin
			fetch_dest = vfddr_pkg::S_SYNC;
		end else if (INSN.op == vfddr_pkg::OP_JUMP || aborting) begin
			fetch_dest = vfddr_pkg::S_FETCH; // RULE19 RULE21 RULE17
		end else if (INSN.op == vfddr_pkg::OP_SKIP || ovr_reg) begin
			fetch_dest = vfddr_pkg::S_DROP; // RULE4 RULE16
		end else begin
			fetch_dest = vfddr_pkg::S_TRIG;
		end
	end

	// Sequencer state, current instruction and byte remainder
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			state_reg <= vfddr_pkg::S_IDLE;
			cur_reg <= '0;
			rem_reg <= 12'h000;
		end else if (!enable) begin
			state_reg <= vfddr_pkg::S_IDLE;
		end else if (perr_ev) begin
			state_reg <= vfddr_pkg::S_HALT; // RULE8
		end else begin
			if (deq && moving) begin
				rem_reg <= rem_reg - step; // RULE10
			end
			unique case (state_reg)
				vfddr_pkg::S_IDLE: state_reg <= vfddr_pkg::S_FETCH;
				vfddr_pkg::S_FETCH: begin
					if (INSN_VALID) begin
						cur_reg <= INSN;
						rem_reg <= INSN.bytes;
						state_reg <= fetch_dest; // RULE1
					end else if (ovr_reg) begin
						state_reg <= vfddr_pkg::S_LDROP; // RULE16
					end
				end
				vfddr_pkg::S_SYNC: begin
					if (deq && sync_hit) begin
						state_reg <= vfddr_pkg::S_FETCH; // RULE24
					end
				end
				vfddr_pkg::S_TRIG: begin
					if (any_full) begin
						state_reg <= vfddr_pkg::S_DROP; // RULE13
					end else if (trig_ok) begin
						state_reg <= vfddr_pkg::S_REQ; // RULE2
					end
				end
				vfddr_pkg::S_REQ: begin
					if (BUS_GNT && !any_nfull) begin
						state_reg <= vfddr_pkg::S_ADDR; // RULE13
					end else if (any_full) begin
						state_reg <= vfddr_pkg::S_DROP; // RULE9
					end
				end
				vfddr_pkg::S_ADDR: state_reg <= vfddr_pkg::S_RESP;
				vfddr_pkg::S_RESP: begin
					if (BUS_TRDY) begin
						state_reg <= ovf_pend_reg ? vfddr_pkg::S_DROP
							: vfddr_pkg::S_BURST; // RULE15
					end
				end
				vfddr_pkg::S_BURST, vfddr_pkg::S_DROP: begin
					if (fend_at_head) begin
						state_reg <= vfddr_pkg::S_FETCH; // RULE21
					end else if (end_insn) begin
						state_reg <= line_long ? vfddr_pkg::S_LDROP
							: vfddr_pkg::S_FETCH; // RULE20 RULE25
					end else if (state_reg == vfddr_pkg::S_BURST
						&& (BUS_STOP || !can_pop)) begin
						state_reg <= vfddr_pkg::S_TRIG; // RULE6
					end else if (state_reg == vfddr_pkg::S_DROP && ovr_reg
						&& cur_reg.op == vfddr_pkg::OP_WRITE && !any_nfull) begin
						state_reg <= vfddr_pkg::S_TRIG; // RULE10
					end
				end
				vfddr_pkg::S_LDROP: begin
					if (fend_at_head || (deq && HEAD.line_end_flag)) begin
						state_reg <= vfddr_pkg::S_FETCH;
					end
				end
				vfddr_pkg::S_HALT: state_reg <= vfddr_pkg::S_HALT;
			endcase
		end
	end

	// Overrun tracking; it persists until occupancy falls back
	always_ff @(posedge REF_CLK) begin
		if (!RSTN || !enable) begin
			ovr_reg <= 1'b0;
			ovf_pend_reg <= 1'b0;
		end else begin
			if ((state_reg == vfddr_pkg::S_TRIG && any_full)
				|| (state_reg == vfddr_pkg::S_REQ && any_full
				&& !(BUS_GNT && !any_nfull))
				|| (state_reg == vfddr_pkg::S_RESP && BUS_TRDY
				&& ovf_pend_reg)) begin
				ovr_reg <= 1'b1; // RULE9 RULE15
			end else if (!any_nfull && (state_reg == vfddr_pkg::S_FETCH
				|| state_reg == vfddr_pkg::S_DROP)) begin
				ovr_reg <= 1'b0; // RULE16
			end
			// Target pointer is committed; overflow now means give up
			if (state_reg == vfddr_pkg::S_RESP) begin
				ovf_pend_reg <= ovf_pend_reg || any_full; // RULE15
			end else begin
				ovf_pend_reg <= 1'b0;
			end
		end
	end

	// Stream alignment state kept across instructions
	always_ff @(posedge REF_CLK) begin
		if (!RSTN || !enable) begin
			synced_reg <= 1'b0;
			fend_abort_reg <= 1'b0;
			flush_reg <= 1'b0;
			owed_reg <= 8'h00;
			drop_owe_reg <= 1'b0;
			disc_reg <= 1'b0;
		end else begin
			if (state_reg == vfddr_pkg::S_SYNC && deq && sync_hit) begin
				synced_reg <= 1'b1;
				fend_abort_reg <= 1'b0; // RULE21
			end else if (fend_at_head) begin
				fend_abort_reg <= 1'b1; // RULE21
			end
			if (lend_early) begin
				flush_reg <= 1'b1; // RULE19
			end else if (INSN_TAKE && INSN.line_end_flag
				&& INSN.op != vfddr_pkg::OP_SYNC
				&& INSN.op != vfddr_pkg::OP_JUMP && !fend_abort_reg) begin
				flush_reg <= 1'b0;
			end
			// Lines shed without a program are paid back one per line end
			if (state_reg == vfddr_pkg::S_LDROP && drop_owe_reg && deq
				&& HEAD.line_end_flag && owed_reg != 8'hFF) begin
				owed_reg <= owed_reg + 8'h01; // RULE17
			end else if (INSN_TAKE && INSN.line_end_flag && !flush_reg
				&& !fend_abort_reg && synced_reg && owed_reg != 8'h00
				&& INSN.op != vfddr_pkg::OP_SYNC
				&& INSN.op != vfddr_pkg::OP_JUMP) begin
				owed_reg <= owed_reg - 8'h01; // RULE17
			end
			if (state_reg == vfddr_pkg::S_FETCH) begin
				drop_owe_reg <= !INSN_VALID && ovr_reg; // RULE16
			end
			// Disconnect in planar bypasses the trigger until drained
			if (state_reg == vfddr_pkg::S_BURST && BUS_STOP && planar
				&& !end_insn) begin
				disc_reg <= 1'b1; // RULE6
			end else if (state_reg == vfddr_pkg::S_FETCH
				|| (state_reg == vfddr_pkg::S_BURST && !can_pop)) begin
				disc_reg <= 1'b0;
			end
		end
	end

	// Byte position within the scan line, kept through discards
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			line_pos_reg <= 12'h000;
		end else if (INSN_TAKE && INSN.line_start_flag) begin
			line_pos_reg <= 12'h000; // RULE25
		end else if (deq && moving) begin
			line_pos_reg <= line_pos_reg + step; // RULE10
		end
	end

	// Sticky event bits; a set in the clearing cycle wins
	always_comb begin
		sts_set = 3'h0;
		sts_set[vfddr_pkg::STS_PARITY_BIT] = perr_ev; // RULE8
		sts_set[vfddr_pkg::STS_SLOW_BIT] = state_reg == vfddr_pkg::S_RESP
			&& BUS_TRDY && ovf_pend_reg; // RULE15
		sts_set[vfddr_pkg::STS_RESYNC_BIT] = lend_early || line_long
			|| fend_at_head || (state_reg == vfddr_pkg::S_SYNC && deq
			&& !sync_hit && synced_reg); // RULE23
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			ctrl_reg <= vfddr_pkg::CTRL_RESET;
			sts_reg <= vfddr_pkg::STS_RESET;
		end else begin
			if (REG_WR && REG_ADDR == vfddr_pkg::ADDR_CTRL) begin
				ctrl_reg <= REG_WDATA[3:0];
			end
			if (REG_WR && REG_ADDR == vfddr_pkg::ADDR_STATUS) begin
				sts_reg <= (sts_reg & ~REG_WDATA[2:0]) | sts_set;
			end else begin
				sts_reg <= sts_reg | sts_set;
			end
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		unique case (REG_ADDR)
			vfddr_pkg::ADDR_CTRL: rd_next = {28'h0000000, ctrl_reg};
			vfddr_pkg::ADDR_STATUS: rd_next = {29'h00000000, sts_reg};
			vfddr_pkg::ADDR_LINE_POS: rd_next = {20'h00000, line_pos_reg};
			vfddr_pkg::ADDR_LINES_OWED: rd_next = {24'h000000, owed_reg};
			default: rd_next = 32'h00000000;
		endcase
	end

	// Data stands only in the cycle after the strobe
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			rd_reg <= 32'h00000000;
		end else begin
			rd_reg <= REG_RD ? rd_next : 32'h00000000;
		end
	end
	assign REG_RDATA = rd_reg;

	// Checks next to the logic they guard
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);

	a_start_headroom: assert property (BUS_START |-> !$past(any_nfull)) // RULE13
		else $error("Address phase started without headroom");
	a_perr_halts: assert property (perr_ev |=> state_reg ==
		vfddr_pkg::S_HALT && sts_reg[vfddr_pkg::STS_PARITY_BIT]) // RULE8
		else $error("Parity error did not halt");
	a_halt_quiet: assert property (state_reg == vfddr_pkg::S_HALT
		|-> !BUS_REQ && !INSN_TAKE && !deq) // RULE8
		else $error("Halted sequencer still active");
	a_skip_no_wait: assert property (state_reg == vfddr_pkg::S_DROP
		&& can_pop && !HEAD.field_end && rem_reg != 12'h000 |-> LUMA_POP
		|| CHA_POP || CHB_POP) // RULE4
		else $error("Skip waited on queue level");
	a_denied_drop: assert property (state_reg == vfddr_pkg::S_REQ
		&& !BUS_GNT && any_full && enable && !perr_ev
		|=> state_reg == vfddr_pkg::S_DROP && ovr_reg) // RULE9
		else $error("Denied bus did not start discard");
	a_slow_target: assert property (state_reg == vfddr_pkg::S_RESP
		&& BUS_TRDY && ovf_pend_reg && enable && !perr_ev |-> BUS_LAST
		##1 sts_reg[vfddr_pkg::STS_SLOW_BIT]) // RULE15
		else $error("Slow target not flagged");
	a_chroma_shed: assert property (planar && (cha_full || chb_full)
		|-> (CHA_POP || !cha_full) && (CHB_POP || !chb_full)) // RULE18
		else $error("Full chroma not discarded");
	a_trigger_wait: assert property (state_reg == vfddr_pkg::S_TRIG
		&& !any_full && avail < trig_dw && {2'b00, avail} <= rem_dw
		&& !disc_reg && enable && !perr_ev
		|=> state_reg == vfddr_pkg::S_TRIG) // RULE2
		else $error("Left trigger wait early");
	a_early_lend: assert property (lend_early && enable && !perr_ev
		|=> flush_reg && sts_reg[vfddr_pkg::STS_RESYNC_BIT]) // RULE19
		else $error("Early line end not handled");
	a_sync_match: assert property (state_reg == vfddr_pkg::S_SYNC && deq
		&& sync_hit && enable && !perr_ev
		|=> synced_reg && state_reg == vfddr_pkg::S_FETCH) // RULE24
		else $error("Sync match not taken");
	a_read_one: assert property (REG_RD ##1 !REG_RD |=> REG_RDATA ==
		32'h00000000)
		else $error("Read data held too long");

	c_burst_done: cover property (BUS_PUSH && end_insn);
	c_sync_hit: cover property (state_reg == vfddr_pkg::S_SYNC && sync_hit);
	c_line_drop: cover property (state_reg == vfddr_pkg::S_LDROP && deq);
	c_slow: cover property (sts_set[vfddr_pkg::STS_SLOW_BIT]);
endmodule // vfddr_transfer_sequencer
`default_nettype wire

// ==== shared/vfddr_pkg.sv ====
// Constants and carriers shared by the video queue drain sequencer
package vfddr_pkg;
	// Queue depths and levels in DWORDs
	localparam logic [6:0] LUMA_DEPTH = 7'h46;
	localparam logic [6:0] LUMA_FULL_LEVEL = 7'h44;
	localparam logic [6:0] LUMA_NEARLY_FULL_LEVEL = 7'h40;
	localparam logic [5:0] CHROMA_DEPTH = 6'h23;
	localparam logic [5:0] CHROMA_FULL_LEVEL = 6'h22;
	localparam logic [5:0] CHROMA_NEARLY_FULL_LEVEL = 6'h20;
	// Trigger level is 4 DWORDs shifted left by the two-bit field
	localparam logic [7:0] TRIG_BASE_DW = 8'h04;
	localparam logic [11:0] DWORD_BYTES = 12'h004;

	// Register byte offsets
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_LINE_POS = 4'h8;
	localparam logic [3:0] ADDR_LINES_OWED = 4'hC;

	// Control fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_PLANAR_BIT = 1;
	localparam int CTRL_TRIG_LSB = 2;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	// Sticky status fields, write one to clear
	localparam int STS_PARITY_BIT = 0;
	localparam int STS_SLOW_BIT = 1;
	localparam int STS_RESYNC_BIT = 2;
	localparam logic [2:0] STS_RESET = 3'h0;

	typedef enum logic [1:0] {
		OP_WRITE,
		OP_SKIP,
		OP_SYNC,
		OP_JUMP
	} vfddr_op_t;

	// One decoded program instruction from the prefetcher
	typedef struct packed {
		vfddr_op_t op;
		logic line_start_flag;
		logic line_end_flag;
		logic [11:0] bytes;
		logic [3:0] status;
	} vfddr_insn_t;

	// Control codes travelling with the DWORD at the queue head
	typedef struct packed {
		logic line_end_flag;
		logic field_end;
		logic [3:0] status;
	} vfddr_head_t;

	typedef enum logic [3:0] {
		S_IDLE,
		S_FETCH,
		S_SYNC,
		S_TRIG,
		S_REQ,
		S_ADDR,
		S_RESP,
		S_BURST,
		S_DROP,
		S_LDROP,
		S_HALT
	} vfddr_state_t;
endpackage

// ==== verification/vfddr_target_model.sv ====
// Bus target model standing in for target memory or a frame buffer
`timescale 1ns/100ps
`default_nettype none
module vfddr_target_model (
	input wire logic clk, // Bus clock
	input wire logic rstn, // Reset, active low
	input wire logic bus_req, // Request from the sequencer
	input wire logic bus_start, // Address phase
	input wire logic bus_push, // Data beat offered
	input wire logic bus_last, // Last cycle of transaction
	input wire logic deny, // Keep the grant low
	input wire logic [7:0] wait_n, // Cycles before target ready
	input wire logic stop_req, // Disconnect with the next ready
	output logic bus_gnt, // Grant
	output logic bus_trdy, // Target ready
	output logic bus_stop, // Disconnect
	output logic [15:0] beats // Beats accepted
);
	logic [7:0] wait_reg;
	logic busy_reg;

	// Grant trails the request by a cycle, as an arbiter would
	always_ff @(posedge clk) begin
		if (!rstn)
			bus_gnt <= 1'b0;
		else
			bus_gnt <= bus_req && !deny;
	end

	// A slow target answers late; ready then holds until the last beat
	always_ff @(posedge clk) begin
		if (!rstn || bus_last) begin
			busy_reg <= 1'b0;
			bus_trdy <= 1'b0;
		end else if (bus_start) begin
			busy_reg <= 1'b1;
			wait_reg <= wait_n;
		end else if (busy_reg && !bus_trdy) begin
			if (wait_reg == 8'h00)
				bus_trdy <= 1'b1;
			else
				wait_reg <= wait_reg - 8'h01;
		end
	end

	// Disconnect only rides on a ready cycle
	assign bus_stop = stop_req && bus_trdy;

	// Count only beats that the target actually took
	always_ff @(posedge clk) begin
		if (!rstn)
			beats <= 16'h0000;
		else if (bus_push && bus_trdy)
			beats <= beats + 16'h0001;
	end
endmodule // vfddr_target_model
`default_nettype wire

// ==== verification/test_video_fifo_dma_drain_resync.sv ====
// Self-checking bench for the queue drain sequencer
`timescale 1ns/100ps
`default_nettype none
module test_video_fifo_dma_drain_resync;
	logic REF_CLK, RSTN, REG_WR, REG_RD, INSN_VALID, INSN_TAKE;
	logic [3:0] REG_ADDR;
	logic [31:0] REG_WDATA, REG_RDATA, e;
	vfddr_pkg::vfddr_insn_t INSN;
	vfddr_pkg::vfddr_head_t HEAD;
	logic FETCH_PERR, LUMA_POP, CHA_POP, CHB_POP, BUS_REQ, BUS_GNT;
	logic BUS_START, BUS_TRDY, BUS_STOP, BUS_PUSH, BUS_LAST;
	logic [6:0] LUMA_CNT, c1;
	logic [5:0] CHA_CNT, CHB_CNT;
	logic deny, stop_req, ok;
	logic [7:0] wait_n;
	logic [15:0] beats;
	int n_mismatch, checks_done;

	vfddr_transfer_sequencer vfddr_transfer_sequencer_i (.REF_CLK(REF_CLK),
		.RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.INSN(INSN), .INSN_VALID(INSN_VALID), .INSN_TAKE(INSN_TAKE),
		.FETCH_PERR(FETCH_PERR), .LUMA_CNT(LUMA_CNT), .CHA_CNT(CHA_CNT),
		.CHB_CNT(CHB_CNT), .HEAD(HEAD), .LUMA_POP(LUMA_POP),
		.CHA_POP(CHA_POP), .CHB_POP(CHB_POP), .BUS_REQ(BUS_REQ),
		.BUS_GNT(BUS_GNT), .BUS_START(BUS_START), .BUS_TRDY(BUS_TRDY),
		.BUS_STOP(BUS_STOP), .BUS_PUSH(BUS_PUSH), .BUS_LAST(BUS_LAST));
	vfddr_target_model vfddr_target_model_i (.clk(REF_CLK), .rstn(RSTN),
		.bus_req(BUS_REQ), .bus_start(BUS_START), .bus_push(BUS_PUSH),
		.bus_last(BUS_LAST), .deny(deny), .wait_n(wait_n),
		.stop_req(stop_req), .bus_gnt(BUS_GNT), .bus_trdy(BUS_TRDY),
		.bus_stop(BUS_STOP), .beats(beats));

	// Queues drain one DWORD per pop; tests refill by setting counts
	always @(posedge REF_CLK) begin
		if (LUMA_POP && LUMA_CNT != 7'h00)
			LUMA_CNT <= LUMA_CNT - 7'h01;
		if (CHA_POP && CHA_CNT != 6'h00)
			CHA_CNT <= CHA_CNT - 6'h01;
		if (CHB_POP && CHB_CNT != 6'h00)
			CHB_CNT <= CHB_CNT - 6'h01;
	end

	initial begin
		REF_CLK = 1'b0;
		forever #20 REF_CLK = ~REF_CLK;
	end

	task chk(input string w, input logic [31:0] x, input logic [31:0] g);
		checks_done++;
		if (g !== x) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", w, x, g);
		end
	endtask

	task results();
		if (n_mismatch == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge REF_CLK);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge REF_CLK);
		REG_WR <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task rd(input logic [3:0] a, input logic [31:0] x, input string w);
		@(posedge REF_CLK);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge REF_CLK);
		REG_RD <= 1'b0;
		@(posedge REF_CLK);
		chk(w, x, REG_RDATA);
	endtask

	function logic sig(input int n);
		case (n)
			0: return BUS_REQ;
			1: return LUMA_POP;
			2: return CHA_POP;
			3: return CHB_POP;
			4: return BUS_START;
			5: return BUS_LAST & BUS_TRDY;
			default: return INSN_TAKE;
		endcase
	endfunction

	// Bounded wait for a design output, sampled at the rising edge
	task hunt(input int n, input int lim);
		ok = 1'b0;
		for (int k = 0; k < lim && !ok; k++) begin
			@(posedge REF_CLK);
			ok = (sig(n) === 1'b1);
		end
	endtask

	task give(input vfddr_pkg::vfddr_insn_t i, input int lim);
		@(posedge REF_CLK);
		INSN <= i;
		INSN_VALID <= 1'b1;
		hunt(6, lim);
		INSN_VALID <= 1'b0;
	endtask

	function vfddr_pkg::vfddr_insn_t ins(input vfddr_pkg::vfddr_op_t o,
		input logic [11:0] b);
		return '{op: o, line_start_flag: 1'b1, line_end_flag: 1'b0,
			bytes: b, status: 4'h5};
	endfunction

	function logic [31:0] cw(input logic pl, input logic [1:0] t);
		return 32'h1 | (32'(pl) << vfddr_pkg::CTRL_PLANAR_BIT) |
			(32'(t) << vfddr_pkg::CTRL_TRIG_LSB);
	endfunction

	// Restart the sequencer and match a SYNC against the head status
	task sync_up(input logic pl, input logic [1:0] t);
		wr(vfddr_pkg::ADDR_CTRL, 32'h0);
		wr(vfddr_pkg::ADDR_CTRL, cw(pl, t));
		HEAD <= '{line_end_flag: 1'b0, field_end: 1'b1, status: 4'h5};
		LUMA_CNT <= 7'h01;
		give(ins(vfddr_pkg::OP_SYNC, 12'h000), 40);
		chk("sync taken", 1, ok);
		// The field code must still stand at the edge that matches it
		@(posedge REF_CLK);
		HEAD <= '0;
		repeat (3) @(posedge REF_CLK);
	endtask

	// Watchdog sized well past the expected run
	initial begin
		#800000;
		n_mismatch++;
		results();
	end

	initial begin
		{RSTN, REG_WR, REG_RD, INSN_VALID, FETCH_PERR} = '0;
		{REG_ADDR, REG_WDATA, INSN, HEAD} = '0;
		{LUMA_CNT, CHA_CNT, CHB_CNT, deny, stop_req, wait_n} = '0;
		repeat (2) @(posedge REF_CLK);
		RSTN <= 1'b1;
		// Reset values, field read-back and an unmapped offset
		for (int a = 0; a < 16; a += 4)
			rd(4'(a), 32'h0, "reset value");
		wr(vfddr_pkg::ADDR_CTRL, 32'hE);
		rd(vfddr_pkg::ADDR_CTRL, 32'hE, "ctrl");
		wr(4'h2, 32'hFFFFFFFF);
		rd(4'h2, 32'h0, "unmapped");
		// Short remainder beats the trigger: 2 DWORDs left, 3 queued
		sync_up(1'b0, 2'h0);
		LUMA_CNT <= 7'h03;
		give(ins(vfddr_pkg::OP_WRITE, 12'h008), 20);
		hunt(5, 40);
		chk("short burst", 1, ok);
		repeat (3) @(posedge REF_CLK);
		chk("beats", 2, beats);
		chk("luma left", 1, LUMA_CNT);
		rd(vfddr_pkg::ADDR_LINE_POS, 32'h8, "line pos");
		// Every trigger code: one below holds off, the level requests
		for (int t = 0; t < 4; t++) begin
			sync_up(1'b0, 2'(t));
			deny <= 1'b1;
			LUMA_CNT <= 7'((4 << t) - 1);
			give(ins(vfddr_pkg::OP_WRITE, 12'h100), 20);
			hunt(0, 12);
			chk("req below trigger", 0, ok);
			LUMA_CNT <= 7'(4 << t);
			hunt(0, 12);
			chk("req at trigger", 1, ok);
		end
		// Bus denied: discard starts at full, not one below
		LUMA_CNT <= 7'h43;
		hunt(1, 10);
		chk("pop below full", 0, ok);
		LUMA_CNT <= 7'h44;
		hunt(1, 10);
		chk("discard at full", 1, ok);
		repeat (10) @(posedge REF_CLK);
		c1 = LUMA_CNT;
		chk("no beat", 2, beats);
		e = 32'(7'h44 - c1) << 2;
		rd(vfddr_pkg::ADDR_LINE_POS, e, "line pos");
		// Address phase waits until the queue drops below nearly full
		LUMA_CNT <= 7'h40;
		deny <= 1'b0;
		hunt(4, 10);
		chk("start at nearly full", 0, ok);
		LUMA_CNT <= 7'h3F;
		hunt(4, 10);
		chk("start below", 1, ok);
		hunt(5, 200);
		repeat (3) @(posedge REF_CLK);
		e = 32'(7'h3F) - (32'h40 - 32'(7'h44 - c1));
		chk("remainder sent", e, LUMA_CNT);
		// Overflow while the target is slow to answer
		sync_up(1'b0, 2'h0);
		wr(vfddr_pkg::ADDR_STATUS, 32'h7);
		wait_n <= 8'd20;
		LUMA_CNT <= 7'h28;
		give(ins(vfddr_pkg::OP_WRITE, 12'h100), 20);
		hunt(4, 20);
		chk("start", 1, ok);
		LUMA_CNT <= 7'h44;
		hunt(5, 40);
		chk("end on response", 1, ok);
		rd(vfddr_pkg::ADDR_STATUS, 32'h2, "slow flag");
		wr(vfddr_pkg::ADDR_STATUS, 32'h2);
		rd(vfddr_pkg::ADDR_STATUS, 32'h0, "flag cleared");
		// Planar: each chroma queue is discarded only once full
		wr(vfddr_pkg::ADDR_CTRL, 32'h0);
		wr(vfddr_pkg::ADDR_CTRL, cw(1'b1, 2'h0));
		for (int q = 0; q < 2; q++) begin
			if (q == 0)
				CHA_CNT <= 6'h21;
			else
				CHB_CNT <= 6'h21;
			hunt(2 + q, 6);
			chk("chroma below full", 0, ok);
			if (q == 0)
				CHA_CNT <= 6'h22;
			else
				CHB_CNT <= 6'h22;
			hunt(2 + q, 6);
			chk("chroma full drop", 1, ok);
		end
		// SKIP runs with fewer DWORDs than the trigger
		sync_up(1'b0, 2'h3);
		LUMA_CNT <= 7'h02;
		// Packed mode counts chroma too, which would mask the trigger
		CHA_CNT <= 6'h00;
		CHB_CNT <= 6'h00;
		give(ins(vfddr_pkg::OP_SKIP, 12'h008), 20);
		repeat (10) @(posedge REF_CLK);
		chk("skip drained", 0, LUMA_CNT);
		// Queue line end ahead of the program aborts to its line end
		HEAD <= '{line_end_flag: 1'b1, field_end: 1'b0, status: 4'h0};
		LUMA_CNT <= 7'h08;
		give(ins(vfddr_pkg::OP_SKIP, 12'h010), 20);
		rd(vfddr_pkg::ADDR_STATUS, 32'h4, "resync flag");
		give(ins(vfddr_pkg::OP_WRITE, 12'h008), 20);
		hunt(0, 8);
		chk("write aborted", 0, ok);
		chk("one DWORD shed", 7, LUMA_CNT);
		wr(vfddr_pkg::ADDR_STATUS, 32'h4);
		// Parity error on fetch halts and flags
		FETCH_PERR <= 1'b1;
		give(ins(vfddr_pkg::OP_WRITE, 12'h008), 20);
		chk("fetch halted", 0, ok);
		rd(vfddr_pkg::ADDR_STATUS, 32'h1, "parity flag");
		results();
	end
endmodule // test_video_fifo_dma_drain_resync
`default_nettype wire
